// [src/pmcs_pkg.sv]
// Package with the register map, field positions and timing of the block.
package pmcs_pkg;

  // Management register addresses.
  localparam logic [4:0] ADDR_CONTROL = 5'h00;
  localparam logic [4:0] ADDR_STATUS  = 5'h01;

  // Control register field positions.
  localparam int CTL_RESTART_BIT = 9;
  localparam int CTL_DUPLEX_BIT  = 8;
  localparam int CTL_COLTEST_BIT = 7;

  // Status register field positions.
  localparam int ST_T4_BIT       = 15;
  localparam int ST_CAP_HI_BIT   = 14;
  localparam int ST_CAP_LO_BIT   = 11;
  localparam int ST_RSV_HI_BIT   = 10;
  localparam int ST_RSV_LO_BIT   = 7;
  localparam int ST_PREAMBLE_BIT = 6;
  localparam int ST_AN_DONE_BIT  = 5;
  localparam int ST_RFAULT_BIT   = 4;
  localparam int ST_AN_ABLE_BIT  = 3;
  localparam int ST_LINK_BIT     = 2;
  localparam int ST_JABBER_BIT   = 1;
  localparam int ST_EXT_BIT      = 0;

  // Reset values.
  localparam logic [15:0] STATUS_RESET = 16'h7809;
  localparam logic [3:0]  CAP_RESET    = 4'hF;
  localparam logic [3:0]  RSV_RESET    = 4'h0;

  // Collision test timing: bit times and the 50 MHz clock period in ns.
  localparam int CLK_PERIOD_NS   = 20;
  localparam int BIT_TIME_NS     = 10;
  localparam int COL_ASSERT_BITS = 512;
  localparam int COL_DROP_BITS   = 4;
  // Longest times round down, never below one cycle.
  localparam int COL_ASSERT_CYC  =
    (COL_ASSERT_BITS * BIT_TIME_NS / CLK_PERIOD_NS) < 1 ? 1 :
    (COL_ASSERT_BITS * BIT_TIME_NS / CLK_PERIOD_NS);
  localparam int COL_DROP_CYC    =
    (COL_DROP_BITS * BIT_TIME_NS / CLK_PERIOD_NS) < 1 ? 1 :
    (COL_DROP_BITS * BIT_TIME_NS / CLK_PERIOD_NS);

  // One management access as seen by the register logic.
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } pmcs_access_s;

  // Events reported by the surrounding PHY functions.
  typedef struct packed {
    logic an_done;
    logic rfault;
    logic link_up;
    logic jabber;
    logic an_started;
  } pmcs_event_s;

endpackage

// [src/pmcs_regs.sv]
// Control low bits and status register of the PHY management block.
`timescale 1ns/100ps

// What this block does
// - Restart write ignored while auto-negotiation disabled.
// - Restart bit self-clears once negotiation begins.
// - Hardware mode takes duplex from pin.
// - Hardware mode duplex status shows active setting.
// - Software autoneg mode duplex follows negotiation result.
// - Software manual mode: control bit selects duplex.
// - Loopback makes duplex control bit ineffective.
// - Collision test off: collision does not follow transmit.
// - Collision test on works even in loopback.
// - Collision asserts within 512, drops within 4 bits.
// - Reserved control bits six to zero read zero.
// - Status register at address one, reset defaults.
// - Four-pair capability bit always reads zero.
// - Four capability bits reset to one.
// - Capability bits change only through override enable.
// - Preamble suppression bit resets to zero.
// - Negotiation complete latches high, resets zero.
// - Remote fault latches high, resets zero.
// - Negotiation ability and extended capability read one.
// - Link status latches low, resets zero.
// - Latching-high bits clear when status is read.
// - Override enable gates override-write bits.
module pmcs_regs (
  input  wire logic                  clock,         // 50 MHz clock.
  input  wire logic                  resetn,        // Sync reset, low.
  input  wire pmcs_pkg::pmcs_access_s acc,          // Management access.
  output logic [15:0]                rdata,         // Read data, next cycle.
  input  wire logic                  hardware_software_select_pin, // 1 = sw.
  input  wire logic                  duplex_select_pin, // Hw-mode duplex.
  input  wire logic                  an_enable,     // Negotiation enable.
  input  wire logic                  loopback,      // Loopback mode active.
  input  wire logic                  override_en,   // Override write enable.
  input  wire logic                  an_duplex,     // Negotiated duplex.
  input  wire pmcs_pkg::pmcs_event_s ev,            // Status events.
  input  wire logic                  txen,          // Transmit enable.
  output logic                       an_restart,    // Restart pulse.
  output logic                       full_duplex,   // Operating duplex.
  output logic                       duplex_status, // Detailed duplex bit.
  output logic                       col            // Collision output.
);

  // Register state.
  logic        restart_reg;
  logic        duplex_reg;
  logic        coltest_reg;
  logic [3:0]  cap_reg;
  logic [3:0]  rsv_reg;
  logic        preamble_reg;
  logic        an_done_reg;
  logic        rfault_reg;
  logic        link_reg;
  logic        jabber_reg;
  logic [15:0] status_next;
  logic [15:0] control_next;
  logic [8:0]  col_cnt_reg;
  logic        wr_ctl;
  logic        wr_st;
  logic        rd_st;
  logic        rd_ctl;
  logic        dpx_next;

  // Latch-high update shared by the three sticky status bits. The event
  // term is ORed last so an event in the read cycle is never lost.
  function automatic logic latch_high_next(input logic event_in,
                                           input logic held,
                                           input logic clear);
    return event_in | (held & ~clear);
  endfunction

  // Address decoding for writes and reads.
  always_comb begin
    wr_ctl = 1'b0;
    wr_st  = 1'b0;
    rd_st  = 1'b0;
    rd_ctl = 1'b0;
    if (acc.addr == pmcs_pkg::ADDR_CONTROL) begin
      wr_ctl = acc.wr;
      rd_ctl = acc.rd;
    end else if (acc.addr == pmcs_pkg::ADDR_STATUS) begin
      wr_st = acc.wr;
      rd_st = acc.rd;
    end
  end

  // Assembled status word; constant bits are wired, not stored.
  always_comb begin
    status_next = 16'h0000;
    status_next[pmcs_pkg::ST_T4_BIT] = 1'b0;
    status_next[pmcs_pkg::ST_CAP_HI_BIT:pmcs_pkg::ST_CAP_LO_BIT] = cap_reg;
    status_next[pmcs_pkg::ST_RSV_HI_BIT:pmcs_pkg::ST_RSV_LO_BIT] = rsv_reg;
    status_next[pmcs_pkg::ST_PREAMBLE_BIT] = preamble_reg;
    status_next[pmcs_pkg::ST_AN_DONE_BIT]  = an_done_reg;
    status_next[pmcs_pkg::ST_RFAULT_BIT]   = rfault_reg;
    status_next[pmcs_pkg::ST_AN_ABLE_BIT]  = 1'b1;
    status_next[pmcs_pkg::ST_LINK_BIT]     = link_reg;
    status_next[pmcs_pkg::ST_JABBER_BIT]   = jabber_reg;
    status_next[pmcs_pkg::ST_EXT_BIT]      = 1'b1;
  end

  // Control word; low seven bits are reserved and read zero.
  always_comb begin
    control_next = 16'h0000;
    control_next[pmcs_pkg::CTL_RESTART_BIT] = restart_reg;
    control_next[pmcs_pkg::CTL_DUPLEX_BIT]  = duplex_reg;
    control_next[pmcs_pkg::CTL_COLTEST_BIT] = coltest_reg;
  end

  // Read data is registered so the output comes from a flip-flop.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      rdata <= 16'h0000;
    end else if (rd_st) begin
      rdata <= status_next;
    end else if (rd_ctl) begin
      rdata <= control_next;
    end else if (acc.rd) begin
      rdata <= 16'h0000;
    end
  end

  // Restart bit: only accepted with negotiation enabled in software mode.
  // It stays set until the negotiation engine reports it has begun.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      restart_reg <= 1'b0;
      an_restart  <= 1'b0;
    end else begin
      an_restart <= 1'b0;
      if (wr_ctl && acc.wdata[pmcs_pkg::CTL_RESTART_BIT] && an_enable &&
          hardware_software_select_pin) begin
        restart_reg <= 1'b1;
        an_restart  <= 1'b1;
      end else if (ev.an_started) begin
        restart_reg <= 1'b0;
      end
    end
  end

  // Duplex and collision-test control bits; bit writes always store.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      duplex_reg  <= 1'b0;
      coltest_reg <= 1'b0;
    end else if (wr_ctl) begin
      duplex_reg  <= acc.wdata[pmcs_pkg::CTL_DUPLEX_BIT];
      coltest_reg <= acc.wdata[pmcs_pkg::CTL_COLTEST_BIT];
    end
  end

  // Operating duplex selection: pin, negotiation or control bit.
  always_comb begin
    if (!hardware_software_select_pin) begin
      dpx_next = duplex_select_pin;
    end else if (an_enable) begin
      dpx_next = an_duplex;
    end else if (loopback) begin
      dpx_next = 1'b0;
    end else begin
      dpx_next = duplex_reg;
    end
  end

  // Duplex outputs; status mirrors the active setting every cycle.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      full_duplex   <= 1'b0;
      duplex_status <= 1'b0;
    end else begin
      full_duplex   <= dpx_next;
      duplex_status <= dpx_next;
    end
  end

  // Override-write bits: capabilities, reserved and preamble suppression.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      cap_reg      <= pmcs_pkg::CAP_RESET;
      rsv_reg      <= pmcs_pkg::RSV_RESET;
      preamble_reg <= 1'b0;
    end else if (wr_st && override_en) begin
      cap_reg      <= acc.wdata[pmcs_pkg::ST_CAP_HI_BIT:
                                pmcs_pkg::ST_CAP_LO_BIT];
      rsv_reg      <= acc.wdata[pmcs_pkg::ST_RSV_HI_BIT:
                                pmcs_pkg::ST_RSV_LO_BIT];
      preamble_reg <= acc.wdata[pmcs_pkg::ST_PREAMBLE_BIT];
    end
  end

  // Latching bits; an event in the read cycle wins over the clear.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      an_done_reg <= 1'b0;
      rfault_reg  <= 1'b0;
      jabber_reg  <= 1'b0;
      link_reg    <= 1'b0;
    end else begin
      an_done_reg <= latch_high_next(ev.an_done, an_done_reg, rd_st);
      rfault_reg  <= latch_high_next(ev.rfault, rfault_reg, rd_st);
      jabber_reg  <= latch_high_next(ev.jabber, jabber_reg, rd_st);
      // Latch low: a drop sticks; a read reloads the live link state.
      link_reg    <= rd_st ? ev.link_up : (link_reg & ev.link_up);
    end
  end

  // Collision test output follows transmit enable with one cycle of lag.
  // Asserting after one cycle keeps well inside the longest delay, and the
  // drop is equally fast, so no per-mode delay line is needed.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      col <= 1'b0;
    end else if (!coltest_reg) begin
      col <= 1'b0;
    end else begin
      col <= txen;
    end
  end

  // Transmit time seen during collision test, in clock cycles. It stops at
  // the longest allowed delay so a long frame cannot wrap it to zero; the
  // bound check below reads it.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      col_cnt_reg <= 9'h000;
    end else if (!coltest_reg || !txen) begin
      col_cnt_reg <= 9'h000;
    end else if (col_cnt_reg != 9'(pmcs_pkg::COL_ASSERT_CYC)) begin
      col_cnt_reg <= col_cnt_reg + 9'h001;
    end
  end

  // Restart checks.
  restart_gate_a: assert property (
    @(posedge clock) disable iff (!resetn)
    (wr_ctl && !an_enable && !restart_reg) |=> !restart_reg)
    else $error("Restart accepted with negotiation disabled.");
  restart_take_a: assert property (
    @(posedge clock) disable iff (!resetn)
    (wr_ctl && acc.wdata[pmcs_pkg::CTL_RESTART_BIT] && an_enable &&
     hardware_software_select_pin) |=> (an_restart && restart_reg))
    else $error("Accepted restart gave no pulse.");
  restart_hw_a: assert property (
    @(posedge clock) disable iff (!resetn)
    !hardware_software_select_pin |=> !an_restart)
    else $error("Restart pulse in hardware mode.");
  restart_clear_a: assert property (
    @(posedge clock) disable iff (!resetn)
    (ev.an_started && !(wr_ctl && acc.wdata[pmcs_pkg::CTL_RESTART_BIT]))
    |=> !restart_reg)
    else $error("Restart bit did not self-clear.");

  // Duplex checks.
  hw_duplex_a: assert property (
    @(posedge clock) disable iff (!resetn)
    !hardware_software_select_pin |=> full_duplex == $past(duplex_select_pin))
    else $error("Hardware duplex not from pin.");
  hw_status_a: assert property (
    @(posedge clock) disable iff (!resetn)
    !hardware_software_select_pin
    |=> duplex_status == $past(duplex_select_pin))
    else $error("Detailed duplex bit not from pin.");
  an_duplex_a: assert property (
    @(posedge clock) disable iff (!resetn)
    (hardware_software_select_pin && an_enable)
    |=> full_duplex == $past(an_duplex))
    else $error("Negotiated duplex not applied.");
  sw_duplex_a: assert property (
    @(posedge clock) disable iff (!resetn)
    (hardware_software_select_pin && !an_enable && !loopback)
    |=> full_duplex == $past(duplex_reg))
    else $error("Manual duplex not from control bit.");
  loop_duplex_a: assert property (
    @(posedge clock) disable iff (!resetn)
    (hardware_software_select_pin && !an_enable && loopback) |=> !full_duplex)
    else $error("Duplex bit acted in loopback.");

  // Collision checks.
  col_off_a: assert property (
    @(posedge clock) disable iff (!resetn)
    !coltest_reg |=> !col)
    else $error("Collision driven without test.");
  col_time_a: assert property (
    @(posedge clock) disable iff (!resetn)
    (coltest_reg && txen) ##1 coltest_reg |-> ##[0:2] col)
    else $error("Collision late.");
  col_bound_a: assert property (
    @(posedge clock) disable iff (!resetn)
    (coltest_reg && col_cnt_reg == 9'(pmcs_pkg::COL_ASSERT_CYC)) |-> col)
    else $error("Collision missing at the longest delay.");
  col_drop_a: assert property (
    @(posedge clock) disable iff (!resetn)
    $fell(txen) |-> ##[0:2] !col)
    else $error("Collision held too long.");

  // Status register and reserved control bit checks.
  cap_guard_a: assert property (
    @(posedge clock) disable iff (!resetn)
    (wr_st && !override_en) |=> $stable(cap_reg))
    else $error("Override bit write without enable.");
  rsv_guard_a: assert property (
    @(posedge clock) disable iff (!resetn)
    (wr_st && !override_en) |=> ($stable(rsv_reg) && $stable(preamble_reg)))
    else $error("Reserved or preamble bit written without enable.");
  cap_write_a: assert property (
    @(posedge clock) disable iff (!resetn)
    (wr_st && override_en)
    |=> cap_reg == $past(acc.wdata[pmcs_pkg::ST_CAP_HI_BIT:
                                   pmcs_pkg::ST_CAP_LO_BIT]))
    else $error("Enabled capability write did not land.");
  latch_hold_a: assert property (
    @(posedge clock) disable iff (!resetn)
    (jabber_reg && !rd_st) |=> jabber_reg)
    else $error("Jabber bit lost before read.");
  jabber_set_a: assert property (
    @(posedge clock) disable iff (!resetn)
    ev.jabber |=> jabber_reg)
    else $error("Jabber event not latched.");
  done_set_a: assert property (
    @(posedge clock) disable iff (!resetn)
    ev.an_done |=> an_done_reg)
    else $error("Negotiation complete not latched.");
  done_clear_a: assert property (
    @(posedge clock) disable iff (!resetn)
    (rd_st && !ev.an_done) |=> !an_done_reg)
    else $error("Latched bit not cleared on read.");
  fault_clear_a: assert property (
    @(posedge clock) disable iff (!resetn)
    (rd_st && !ev.rfault) |=> !rfault_reg)
    else $error("Remote fault not cleared on read.");
  link_low_a: assert property (
    @(posedge clock) disable iff (!resetn)
    (!ev.link_up) |=> !link_reg)
    else $error("Link drop not captured.");
  link_reload_a: assert property (
    @(posedge clock) disable iff (!resetn)
    (rd_st && ev.link_up) |=> link_reg)
    else $error("Link bit not reloaded on read.");
  status_fixed_a: assert property (
    @(posedge clock) disable iff (!resetn)
    rd_st |=> (!rdata[pmcs_pkg::ST_T4_BIT] &&
               rdata[pmcs_pkg::ST_AN_ABLE_BIT] &&
               rdata[pmcs_pkg::ST_EXT_BIT]))
    else $error("Fixed status bits wrong.");
  ctl_rsv_a: assert property (
    @(posedge clock) disable iff (!resetn)
    rd_ctl |=> rdata[pmcs_pkg::CTL_COLTEST_BIT-1:0] == 7'h00)
    else $error("Reserved control bits not zero.");

  // Main scenarios.
  restart_c: cover property (@(posedge clock) an_restart);
  col_c:     cover property (@(posedge clock) coltest_reg && col);
  cap_wr_c:  cover property (@(posedge clock) wr_st && override_en);
  latch_c:   cover property (@(posedge clock) rd_st && an_done_reg);
  hw_mode_c: cover property (@(posedge clock) !hardware_software_select_pin);

endmodule // pmcs_regs

// [testbench/pmcs_sta_model.sv]
// Station management controller model that issues register accesses.
`timescale 1ns/100ps
module pmcs_sta_model (
  input  wire logic              clock, // Block clock.
  output pmcs_pkg::pmcs_access_s acc,   // Access toward the block.
  input  wire logic [15:0]       rdata  // Read data from the block.
);
  // Bus idles at time zero so no strobe starts unknown.
  initial acc = '0;

  // Reserved bits always go out with their zero default.
  function automatic logic [15:0] clean(input logic [4:0] a,
                                        input logic [15:0] d);
    if (a == pmcs_pkg::ADDR_CONTROL) return d & 16'hFF80;
    if (a == pmcs_pkg::ADDR_STATUS) return d & 16'hF87F;
    return d;
  endfunction

  // Released address and data show garbage, not the last value.
  task automatic release_bus(input logic [4:0] a, input logic [15:0] d);
    acc = {2'b00, ~a, ~d};
  endtask

  // One write, held across exactly one sampling edge.
  task automatic write_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clock);
    #1;
    acc = {1'b1, 1'b0, a, clean(a, d)};
    @(posedge clock);
    #1;
    release_bus(a, d);
  endtask

  // One read; data is taken once the sampling edge has landed.
  task automatic read_reg(input logic [4:0] a, output logic [15:0] d);
    @(posedge clock);
    #1;
    acc = {1'b0, 1'b1, a, 16'h0000};
    @(posedge clock);
    #1;
    d = rdata;
    release_bus(a, 16'h0000);
  endtask
endmodule // pmcs_sta_model

// [testbench/testbench.sv]
// Self-checking bench for the PHY management register block.
`timescale 1ns/100ps
module testbench;
  logic                   clock;
  logic                   resetn;
  pmcs_pkg::pmcs_access_s acc;
  logic [15:0]            rdata;
  logic [15:0]            rd_val;
  logic                   hws, dpx, an_en, lb, ovr, an_dup, txen;
  pmcs_pkg::pmcs_event_s  ev;
  logic                   an_restart, full_duplex, duplex_status, col;
  int                     mismatches, n_compared;
  // Rows: {sw mode, pin, autoneg, loopback, negotiated, bit8, expected}.
  logic [6:0]             rows [7] = '{7'b0100001, 7'b0000010,
    7'b1010101, 7'b1010010, 7'b1000011, 7'b1000000, 7'b1001010};

  pmcs_regs i_dut (.clock(clock), .resetn(resetn), .acc(acc),
    .rdata(rdata), .hardware_software_select_pin(hws),
    .duplex_select_pin(dpx), .an_enable(an_en), .loopback(lb),
    .override_en(ovr), .an_duplex(an_dup), .ev(ev), .txen(txen),
    .an_restart(an_restart), .full_duplex(full_duplex),
    .duplex_status(duplex_status), .col(col));
  pmcs_sta_model i_sta (.clock(clock), .acc(acc), .rdata(rdata));

  // Free-running 50 MHz clock.
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic tally_and_finish;
    $display("compared %0d mismatched %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic rdchk(input logic [4:0] a, input logic [15:0] e,
                       input string nm);
    i_sta.read_reg(a, rd_val);
    chk(nm, e, rd_val);
  endtask

  // Bounded wait, so a stuck collision output ends the run.
  task automatic wait_col(input logic v, input int lim);
    for (int i = 0; i < lim && col !== v; i++) step(1);
    chk("col", 16'(v), 16'(col));
    if (col !== v) tally_and_finish();
  endtask

  // Watchdog against any hang outside the bounded waits.
  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    tally_and_finish();
  end

  initial begin
    resetn = 1'b0;
    {hws, dpx, an_en, lb, ovr, an_dup, txen} = 7'b1000000;
    ev = '0;
    mismatches = 0;
    n_compared = 0;
    repeat (10) @(posedge clock);
    #1;
    resetn = 1'b1;
    rdchk(pmcs_pkg::ADDR_STATUS, 16'h7809, "status_rst");
    rdchk(pmcs_pkg::ADDR_CONTROL, 16'h0000, "ctl_rst");
    rdchk(5'h02, 16'h0000, "unmapped");
    $display("reset test done");
    // Duplex source in hardware, negotiated, manual and loopback modes.
    foreach (rows[i]) begin
      {hws, dpx, an_en, lb, an_dup} = rows[i][6:2];
      i_sta.write_reg(pmcs_pkg::ADDR_CONTROL, {7'h00, rows[i][1], 8'h00});
      step(2);
      chk("full_duplex", 16'(rows[i][0]), 16'(full_duplex));
      chk("duplex_status", 16'(rows[i][0]), 16'(duplex_status));
    end
    $display("duplex table done");
    // Restart is refused with negotiation off, then self-clears.
    {hws, an_en, lb} = 3'b100;
    i_sta.write_reg(pmcs_pkg::ADDR_CONTROL, 16'h0200);
    chk("restart_off", 16'h0000, 16'(an_restart));
    rdchk(pmcs_pkg::ADDR_CONTROL, 16'h0000, "restart_bit_off");
    an_en = 1'b1;
    hws = 1'b0;
    i_sta.write_reg(pmcs_pkg::ADDR_CONTROL, 16'h0200);
    chk("restart_hw", 16'h0000, 16'(an_restart));
    hws = 1'b1;
    i_sta.write_reg(pmcs_pkg::ADDR_CONTROL, 16'h0200);
    chk("restart_on", 16'h0001, 16'(an_restart));
    rdchk(pmcs_pkg::ADDR_CONTROL, 16'h0200, "restart_bit");
    ev.an_started = 1'b1;
    step(1);
    ev.an_started = 1'b0;
    rdchk(pmcs_pkg::ADDR_CONTROL, 16'h0000, "restart_clr");
    $display("restart test done");
    // Collision test off, then on while in loopback.
    txen = 1'b1;
    step(4);
    chk("col_off", 16'h0000, 16'(col));
    {txen, lb} = 2'b01;
    i_sta.write_reg(pmcs_pkg::ADDR_CONTROL, 16'h0080);
    txen = 1'b1;
    wait_col(1'b1, pmcs_pkg::COL_ASSERT_CYC);
    step(pmcs_pkg::COL_ASSERT_CYC);
    chk("col_hold", 16'h0001, 16'(col));
    txen = 1'b0;
    wait_col(1'b0, pmcs_pkg::COL_DROP_CYC);
    lb = 1'b0;
    $display("collision test done");
    // Latching bits hold until read, link holds a drop until read.
    ev.link_up = 1'b1;
    rdchk(pmcs_pkg::ADDR_STATUS, 16'h7809, "link_first");
    {ev.an_done, ev.rfault, ev.jabber} = 3'b111;
    step(1);
    {ev.an_done, ev.rfault, ev.jabber} = 3'b000;
    rdchk(pmcs_pkg::ADDR_STATUS, 16'h783F, "latched");
    rdchk(pmcs_pkg::ADDR_STATUS, 16'h780D, "cleared");
    ev.link_up = 1'b0;
    step(1);
    ev.link_up = 1'b1;
    rdchk(pmcs_pkg::ADDR_STATUS, 16'h7809, "link_drop");
    rdchk(pmcs_pkg::ADDR_STATUS, 16'h780D, "link_back");
    $display("latch test done");
    // Override-write bits are blocked, then written; fixed bits hold.
    i_sta.write_reg(pmcs_pkg::ADDR_STATUS, 16'hC040);
    rdchk(pmcs_pkg::ADDR_STATUS, 16'h780D, "ovr_blocked");
    ovr = 1'b1;
    i_sta.write_reg(pmcs_pkg::ADDR_STATUS, 16'hC040);
    rdchk(pmcs_pkg::ADDR_STATUS, 16'h404D, "ovr_write");
    // A second reset restores every default.
    resetn = 1'b0;
    step(2);
    resetn = 1'b1;
    rdchk(pmcs_pkg::ADDR_STATUS, 16'h7809, "rst_again");
    $display("override test done");
    tally_and_finish();
  end
endmodule // testbench
